// [hdl/eeprom_defs.svh]
`ifndef EEPROM_DEFS_SVH
`define EEPROM_DEFS_SVH
// Clock rate in kHz
`define CLK_KHZ 100000
// Type code parameter default; value is arbitrary
`define TYPE_CODE_DEFAULT 4'h5
// Page and array geometry
`define PAGE_BYTES 64
`define MEM_BYTES 4096
// Reset hold interval in ms, and cycles
`define RESET_HOLD_MS 200
`define RESET_HOLD_CYC (`RESET_HOLD_MS * `CLK_KHZ)
// Manual reset glitch width in ns, and cycles (round up)
`define MR_GLITCH_NS 100
`define MR_GLITCH_CYC ((`MR_GLITCH_NS * (`CLK_KHZ / 1000) + 999) / 1000)
// Program cycle time in ms, and cycles (round down)
`define PROG_CYCLE_MS 5
`define PROG_CYCLE_CYC (`PROG_CYCLE_MS * `CLK_KHZ)
// Field positions of the address byte
`define DIR_BIT 0
`endif

// [hdl/eeprom_pkg.sv]
package eeprom_pkg;
  // Serial engine states, one-hot
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_ADDR = 7'h02,
    ST_ACK = 7'h04,
    ST_RX = 7'h08,
    ST_TX = 7'h10,
    ST_RACK = 7'h20,
    ST_WAIT = 7'h40
  } bus_state_e;
  // Synchronised bus lines
  typedef struct packed {
    logic scl;
    logic sda;
  } bus_lines_s;
  // Supervisor inputs
  typedef struct packed {
    logic supply_ok;
    logic manual_rst_n;
  } sup_in_s;
endpackage : eeprom_pkg

// [hdl/reset_supervisor.sv]
`timescale 1ns/1ps
`include "eeprom_defs.svh"
// Power-up, brown-out and manual reset timer
module reset_supervisor #(
  parameter int HOLD_CYC = `RESET_HOLD_CYC,
  parameter int GLITCH_CYC = `MR_GLITCH_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire eeprom_pkg::sup_in_s sup,
  output logic sys_reset_q
);
  import eeprom_pkg::*;
  // Three-stage synchronisers
  logic [2:0] ok_sync_q;
  logic [2:0] mr_sync_q;
  logic ok_q;
  logic mr_q;
  logic [31:0] glitch_q;
  logic [31:0] hold_q;
  logic mr_fall;
  // Filtered manual level goes low only after a long enough pulse
  assign mr_fall = mr_q && (glitch_q >= 32'(GLITCH_CYC));
  // Synchronise and filter inputs
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ok_sync_q <= 3'h0;
      mr_sync_q <= 3'h7;
      ok_q <= 1'b0;
      mr_q <= 1'b1;
      glitch_q <= 32'h0;
    end
    else
    begin
      ok_sync_q <= {ok_sync_q[1:0], sup.supply_ok};
      mr_sync_q <= {mr_sync_q[1:0], sup.manual_rst_n};
      // Accept when second and third stages agree
      if (ok_sync_q[1] == ok_sync_q[2])
        ok_q <= ok_sync_q[2];
      // Count low time; short pulses ignored
      if (mr_sync_q[1] == mr_sync_q[2] && !mr_sync_q[2])
        glitch_q <= glitch_q + 32'h1;
      else
        glitch_q <= 32'h0;
      if (mr_fall)
        mr_q <= 1'b0;
      else if (mr_sync_q[1] == mr_sync_q[2] && mr_sync_q[2])
        mr_q <= 1'b1;
    end
  end
  // Hold timer restarted by low supply or manual edge
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      hold_q <= 32'h0;
      sys_reset_q <= 1'b1;
    end
    else if (!ok_q)
    begin
      // Immediate assert below trip level
      hold_q <= 32'h0;
      sys_reset_q <= 1'b1;
    end
    else if (mr_fall)
    begin
      // Manual edge restarts the full interval
      hold_q <= 32'h0;
      sys_reset_q <= 1'b1;
    end
    else if (hold_q < 32'(HOLD_CYC))
    begin
      hold_q <= hold_q + 32'h1;
      sys_reset_q <= 1'b1;
    end
    else
      sys_reset_q <= 1'b0;
  end
endmodule : reset_supervisor

// [hdl/serial_eeprom_slave.sv]
// Functional notes
// - Start is SDA fall while SCL high
// - Stop is SDA rise while SCL high
// - SDA change with SCL high is condition
// - Match four-bit type code, three-bit select
// - Direction bit one reads, zero writes
// - Receiver acknowledges on ninth clock
// - Acknowledge address and every written byte
// - Read: send byte, sample acknowledge, continue
// - Stop after write starts busy programming
// - Page write takes up to 64 bytes
// - Write pointer wraps inside page
// - No acknowledge while programming, then acknowledge
// - Counter holds last plus one, wraps
// - Sequential read advances full counter
// - Reset aborts and refuses bus traffic
// - Reset blocks new programs, not running
// - Reset held 200 ms after supply good
// - Reset asserts when supply drops
// - Manual edge gives 200 ms reset
// - Manual pulses under 100 ns ignored
// - Programming finishes within 5 ms
`timescale 1ns/1ps
`include "eeprom_defs.svh"
module serial_eeprom_slave #(
  parameter int PAGE = `PAGE_BYTES,
  parameter int DEPTH = `MEM_BYTES,
  parameter int PROG_CYC = `PROG_CYCLE_CYC,
  parameter int HOLD_CYC = `RESET_HOLD_CYC,
  parameter logic [3:0] TYPE_CODE = `TYPE_CODE_DEFAULT
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  input wire logic [2:0] dev_sel,
  input wire logic supply_ok,
  input wire logic manual_rst_n_i,
  output logic reset_o,
  output logic reset_oe_n,
  output logic busy
);
  import eeprom_pkg::*;
  localparam int AW = $clog2(DEPTH);
  localparam int PW = $clog2(PAGE);
  // Memory array and page buffer
  logic [7:0] mem_q [DEPTH];
  logic [7:0] page_q [PAGE];
  logic [PAGE-1:0] page_vld_q;
  // Bus synchronisers, three stages
  logic [2:0] scl_sync_q;
  logic [2:0] sda_sync_q;
  bus_lines_s line_q;
  bus_lines_s line_prev_q;
  // Serial engine state
  bus_state_e state_q;
  logic [3:0] bit_q;
  logic [7:0] shift_q;
  logic rd_q;
  logic [1:0] abyte_q;
  logic [AW-1:0] ptr_q;
  logic [AW-1:0] wbase_q;
  logic wr_pend_q;
  logic sda_drv_q;
  logic sda_val_q;
  // Programming timer
  logic [31:0] prog_q;
  logic prog_q_act;
  logic sys_reset;
  sup_in_s sup;
  // Conditions and edges
  wire scl_rise = line_q.scl && !line_prev_q.scl;
  wire scl_fall = !line_q.scl && line_prev_q.scl;
  wire start_c = line_q.scl && line_prev_q.scl &&
    !line_q.sda && line_prev_q.sda;
  wire stop_c = line_q.scl && line_prev_q.scl &&
    line_q.sda && !line_prev_q.sda;
  wire [7:0] rx_byte = {shift_q[6:0], line_q.sda};
  wire addr_hit = rx_byte[7:4] == TYPE_CODE &&
    rx_byte[3:1] == dev_sel;
  wire [AW-1:0] page_mask = AW'(PAGE - 1);
  wire [PW-1:0] woff = ptr_q[PW-1:0];
  wire [AW-1:0] page_slot = AW'(wbase_q & ~page_mask);
  wire start_prog = stop_c && wr_pend_q && !sys_reset &&
    !prog_q_act;

  // Next address with wrap over the whole array
  function automatic logic [AW-1:0] inc_addr(input logic [AW-1:0] a);
    inc_addr = a + AW'(1);
  endfunction : inc_addr

  // Supervisor sub-block
  assign sup.supply_ok = supply_ok;
  assign sup.manual_rst_n = manual_rst_n_i;
  reset_supervisor #(
    .HOLD_CYC(HOLD_CYC),
    .GLITCH_CYC(`MR_GLITCH_CYC)
  ) u_sup (
    .clk(clk),
    .rst_n(rst_n),
    .sup(sup),
    .sys_reset_q(sys_reset)
  );

  // Bus line synchronisers; accept when stages two and three agree
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      scl_sync_q <= 3'h7;
      sda_sync_q <= 3'h7;
      line_q <= 2'b11;
      line_prev_q <= 2'b11;
    end
    else
    begin
      scl_sync_q <= {scl_sync_q[1:0], scl_i};
      sda_sync_q <= {sda_sync_q[1:0], sda_i};
      if (scl_sync_q[1] == scl_sync_q[2])
        line_q.scl <= scl_sync_q[2];
      if (sda_sync_q[1] == sda_sync_q[2])
        line_q.sda <= sda_sync_q[2];
      line_prev_q <= line_q;
    end
  end

  // Programming timer; runs on even under reset
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      prog_q <= 32'h0;
    else if (start_prog)
      prog_q <= 32'(PROG_CYC);
    else if (prog_q != 32'h0)
      prog_q <= prog_q - 32'h1;
  end
  assign prog_q_act = prog_q != 32'h0;

  // Commit page buffer at end of programming
  always_ff @(posedge clk)
  begin
    if (prog_q == 32'h1)
    begin
      for (int i = 0; i < PAGE; i++)
        if (page_vld_q[i])
          mem_q[page_slot | AW'(i)] <= page_q[i];
    end
    else if (state_q == ST_RX && scl_rise && bit_q == 4'h7 &&
             abyte_q == 2'h2)
      page_q[woff] <= rx_byte;
  end

  // Serial engine
  always_ff @(posedge clk)
  begin
    if (!rst_n || sys_reset)
    begin
      // Abort all traffic under reset
      state_q <= ST_IDLE;
      bit_q <= 4'h0;
      shift_q <= 8'h00;
      rd_q <= 1'b0;
      abyte_q <= 2'h0;
      wr_pend_q <= 1'b0;
      sda_drv_q <= 1'b0;
      sda_val_q <= 1'b1;
      // Valid map kept under supervisor reset, so that a running
      // program still commits its page; a new write clears it
      if (!rst_n)
      begin
        ptr_q <= '0;
        wbase_q <= '0;
        page_vld_q <= '0;
      end
    end
    else if (start_c)
    begin
      // Start or repeated start
      state_q <= ST_ADDR;
      bit_q <= 4'h0;
      sda_drv_q <= 1'b0;
    end
    else if (stop_c)
    begin
      state_q <= ST_IDLE;
      sda_drv_q <= 1'b0;
      wr_pend_q <= 1'b0;
      // Last written slot plus one; page base from the first address
      if (wr_pend_q)
        ptr_q <= inc_addr((wbase_q & ~page_mask) |
          (AW'(woff - PW'(1)) & page_mask));
    end
    else
    begin
      case (state_q)
        ST_IDLE:
          sda_drv_q <= 1'b0;
        ST_ADDR:
        begin
          if (scl_rise)
          begin
            shift_q <= rx_byte;
            bit_q <= bit_q + 4'h1;
            if (bit_q == 4'h7)
            begin
              // Busy device withholds acknowledge
              if (addr_hit && !prog_q_act)
              begin
                rd_q <= rx_byte[`DIR_BIT];
                state_q <= ST_ACK;
                if (!rx_byte[`DIR_BIT])
                begin
                  abyte_q <= 2'h0;
                  page_vld_q <= '0;
                end
              end
              else
                state_q <= ST_WAIT;
            end
          end
        end
        ST_ACK:
        begin
          // Drive acknowledge over the ninth clock
          if (scl_fall && !sda_drv_q)
          begin
            sda_drv_q <= 1'b1;
            sda_val_q <= 1'b0;
          end
          else if (scl_fall)
          begin
            bit_q <= 4'h0;
            if (rd_q)
            begin
              // First data bit of read byte
              shift_q <= mem_q[ptr_q];
              sda_val_q <= mem_q[ptr_q][7];
              state_q <= ST_TX;
            end
            else
            begin
              sda_drv_q <= 1'b0;
              state_q <= ST_RX;
            end
          end
        end
        ST_RX:
        begin
          if (scl_rise)
          begin
            shift_q <= rx_byte;
            bit_q <= bit_q + 4'h1;
            if (bit_q == 4'h7)
            begin
              state_q <= ST_ACK;
              case (abyte_q)
                // High address byte first
                2'h0: ptr_q <= AW'({rx_byte, ptr_q[7:0]});
                2'h1: ptr_q <= {ptr_q[AW-1:8], rx_byte};
                default:
                begin
                  // Buffered data; offset wraps in page
                  page_vld_q[woff] <= 1'b1;
                  if (!wr_pend_q)
                    wbase_q <= ptr_q;
                  ptr_q <= {ptr_q[AW-1:PW], woff + PW'(1)};
                  wr_pend_q <= 1'b1;
                end
              endcase
              if (abyte_q != 2'h2)
                abyte_q <= abyte_q + 2'h1;
            end
          end
        end
        ST_TX:
        begin
          if (scl_fall)
          begin
            bit_q <= bit_q + 4'h1;
            if (bit_q == 4'h7)
            begin
              // Release line to sample acknowledge
              sda_drv_q <= 1'b0;
              ptr_q <= inc_addr(ptr_q);
              state_q <= ST_RACK;
            end
            else
            begin
              sda_val_q <= shift_q[6];
              shift_q <= {shift_q[6:0], 1'b0};
            end
          end
        end
        ST_RACK:
        begin
          // Master's answer sampled on the ninth rise
          if (scl_rise && line_q.sda)
            state_q <= ST_WAIT;
          else if (scl_fall)
          begin
            // Acknowledged; drive the next byte only once the clock
            // is low, so the line never moves while it is high
            bit_q <= 4'h0;
            shift_q <= mem_q[ptr_q];
            sda_val_q <= mem_q[ptr_q][7];
            sda_drv_q <= 1'b1;
            state_q <= ST_TX;
          end
        end
        ST_WAIT:
          sda_drv_q <= 1'b0;
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  // Registered pin drive; enable low while driving
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      sda_o <= 1'b1;
      sda_oe_n <= 1'b1;
      reset_o <= 1'b0;
      reset_oe_n <= 1'b0;
      busy <= 1'b0;
    end
    else
    begin
      sda_o <= sda_val_q;
      sda_oe_n <= !sda_drv_q;
      reset_o <= 1'b0;
      reset_oe_n <= !sys_reset;
      busy <= prog_q_act;
    end
  end
endmodule : serial_eeprom_slave

// [test/bus_master_model.sv]
`timescale 1ns/1ps
// Two-wire master; data is open drain
module bus_master_model (
  input wire logic clk,
  input wire logic sda_in,
  output logic scl,
  output logic sda_rel
);
  localparam int HB = 10; // Half bit in clocks
  initial
  begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end
  // Wait, then move just after the edge
  task automatic tk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tk
  // Start or repeated start
  task automatic start();
    tk(2);
    sda_rel = 1'b1;
    tk(HB);
    scl = 1'b1;
    tk(HB);
    sda_rel = 1'b0;
    tk(HB);
    scl = 1'b0;
  endtask : start
  // Stop closes each operation
  task automatic stop();
    tk(2);
    sda_rel = 1'b0;
    tk(HB);
    scl = 1'b1;
    tk(HB);
    sda_rel = 1'b1;
    tk(HB);
  endtask : stop
  // One bit; data held while clock high
  task automatic bit_x(input logic b, output logic r);
    tk(2);
    sda_rel = b;
    tk(HB);
    scl = 1'b1;
    tk(HB);
    r = sda_in;
    scl = 1'b0;
  endtask : bit_x
  // Byte out, MSB first
  task automatic send(input logic [7:0] d, output logic nak);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_x(d[i], r);
    bit_x(1'b1, nak);
  endtask : send
  // Byte in; nak low asks for more
  task automatic recv(input logic nak, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_x(1'b1, d[i]);
    bit_x(nak, r);
  endtask : recv
endmodule : bus_master_model

// [test/serial_eeprom_slave_chk.sv]
`timescale 1ns/1ps
// Pin-level checks on the slave
module serial_eeprom_slave_chk #(
  parameter int PROG_CYC = 100,
  parameter int HOLD_CYC = 200
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl_i,
  input wire logic sda_o,
  input wire logic sda_oe_n,
  input wire logic supply_ok,
  input wire logic reset_o,
  input wire logic reset_oe_n,
  input wire logic busy
);
  int busy_cnt_q; // Length of running program
  int low_cnt_q; // Length of reset assertion
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // Run counters
  always_ff @(posedge clk)
  begin
    busy_cnt_q <= (rst_n && busy) ? busy_cnt_q + 1 : 0;
    low_cnt_q <= (rst_n && !reset_oe_n) ? low_cnt_q + 1 : 0;
  end
  a_busy_quiet: assert property (busy |-> sda_oe_n)
    else $error("drove data while programming");
  a_prog_length: assert property ($fell(busy) |->
    busy_cnt_q == PROG_CYC)
    else $error("program length wrong");
  a_prog_bound: assert property (busy |-> busy_cnt_q < PROG_CYC)
    else $error("program too long");
  // Two cycles allowed for the output register
  a_reset_min: assert property ($rose(reset_oe_n) |->
    low_cnt_q >= HOLD_CYC - 2)
    else $error("reset released early");
  a_supply_drop: assert property (!supply_ok [*8] |-> !reset_oe_n)
    else $error("reset missing on low supply");
  a_reset_abort: assert property (!reset_oe_n [*3] |-> sda_oe_n)
    else $error("bus driven under reset");
  a_no_new_prog: assert property (!reset_oe_n [*3] |-> !$rose(busy))
    else $error("program started under reset");
  a_high_steady: assert property (scl_i [*8] |-> $stable(sda_oe_n) &&
    (sda_oe_n || $stable(sda_o)))
    else $error("data moved with clock high");
  a_pin_low: assert property (!reset_oe_n |-> !reset_o)
    else $error("reset pin not pulled low");
  c_prog: cover property ($fell(busy));
  c_release: cover property ($rose(reset_oe_n));
  c_ack: cover property (!sda_oe_n && !sda_o);
endmodule : serial_eeprom_slave_chk

bind serial_eeprom_slave serial_eeprom_slave_chk #(
  .PROG_CYC(PROG_CYC),
  .HOLD_CYC(HOLD_CYC)
) chk_i (
  .clk(clk),
  .rst_n(rst_n),
  .scl_i(scl_i),
  .sda_o(sda_o),
  .sda_oe_n(sda_oe_n),
  .supply_ok(supply_ok),
  .reset_o(reset_o),
  .reset_oe_n(reset_oe_n),
  .busy(busy)
);

// [test/serial_eeprom_slave_tb.sv]
`timescale 1ns/1ps
// Bench for the serial memory slave
module serial_eeprom_slave_tb;
  localparam int PROG = 300; // Short program, longer than one address byte
  localparam int HOLD = 200; // Short reset hold
  localparam logic [3:0] TC = 4'h6; // Type code, arbitrary
  localparam logic [2:0] DS = 3'h5; // Select pins
  typedef struct packed {logic [15:0] wa, ra; logic [7:0] d;} row_s;
  // Rows: write address, read address, data
  row_s rows [3] = '{{16'h0000, 16'h0000, 8'h5a},
    {16'h0fff, 16'h0fff, 8'ha5}, {16'hf123, 16'h0123, 8'h3c}};
  logic [7:0] bad [2] = '{{TC, ~DS, 1'b0}, {~TC, DS, 1'b1}};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic supply_ok = 1'b0;
  logic mr_n = 1'b1; // Push-button drive
  logic scl, sda_rel, sda_o, sda_oe_n, reset_o, reset_oe_n, busy, nak;
  logic [7:0] rb;
  logic [7:0] exq [$]; // Bytes the next read returns
  int err_count = 0;
  int tests_run = 0;
  int cyc_n = 0;
  int k;
  int t0; // Cycle of the manual reset edge
  // Open-drain wires with pull-ups
  wire sda_w = sda_rel & (sda_oe_n | sda_o);
  wire mr_w = mr_n & (reset_oe_n | reset_o);
  always #5 clk = ~clk;
  serial_eeprom_slave #(.PROG_CYC(PROG), .HOLD_CYC(HOLD), .TYPE_CODE(TC))
    serial_eeprom_slave_i (.clk(clk), .rst_n(rst_n), .scl_i(scl),
    .sda_i(sda_w), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .dev_sel(DS),
    .supply_ok(supply_ok), .manual_rst_n_i(mr_w), .reset_o(reset_o),
    .reset_oe_n(reset_oe_n), .busy(busy));
  bus_master_model bus_master_model_i (.clk(clk), .sda_in(sda_w),
    .scl(scl), .sda_rel(sda_rel));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  // Select for write, then high and low address
  task automatic aph(input logic [15:0] a);
    bus_master_model_i.start();
    bus_master_model_i.send({TC, DS, 1'b0}, nak);
    chk(8'(nak), 8'h0);
    bus_master_model_i.send(a[15:8], nak);
    chk(8'(nak), 8'h0);
    bus_master_model_i.send(a[7:0], nak);
    chk(8'(nak), 8'h0);
  endtask : aph
  task automatic wr(input logic [15:0] a, input logic [7:0] d, input int n);
    aph(a);
    for (int i = 0; i < n; i++)
    begin
      bus_master_model_i.send(d + 8'(i), nak);
      chk(8'(nak), 8'h0);
    end
    bus_master_model_i.stop();
  endtask : wr
  // Poll until the program is done
  task automatic poll();
    for (int i = 0; i < 20 && (i == 0 || nak); i++)
    begin
      bus_master_model_i.start();
      bus_master_model_i.send({TC, DS, 1'b0}, nak);
      bus_master_model_i.stop();
      if (i == 0)
        chk(8'(nak), 8'h1);
    end
    chk(8'(nak), 8'h0);
  endtask : poll
  // Random or current read of exq bytes
  task automatic rd(input logic [15:0] a, input logic cur);
    if (!cur)
      aph(a);
    bus_master_model_i.start();
    bus_master_model_i.send({TC, DS, 1'b1}, nak);
    chk(8'(nak), 8'h0);
    foreach (exq[i])
    begin
      bus_master_model_i.recv(i == exq.size() - 1, rb);
      chk(rb, exq[i]);
    end
    cyc(20);
    chk(8'(sda_oe_n), 8'h1);
    bus_master_model_i.stop();
  endtask : rd
  task automatic wrel();
    for (k = 0; reset_oe_n !== 1'b1 && k < 2000; k++)
      cyc(1);
  endtask : wrel
  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : tally_and_finish
  // Hang guard
  always @(posedge clk)
  begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 80000)
    begin
      err_count++;
      tally_and_finish();
    end
  end
  initial
  begin
    cyc(8);
    rst_n = 1'b1;
    cyc(50);
    chk(8'(reset_oe_n), 8'h0);
    bus_master_model_i.start();
    bus_master_model_i.send({TC, DS, 1'b0}, nak);
    chk(8'(nak), 8'h1);
    bus_master_model_i.stop();
    supply_ok = 1'b1;
    wrel();
    chk(8'(k >= HOLD && k <= HOLD + 10), 8'h1);
    foreach (rows[i])
    begin
      wr(rows[i].wa, rows[i].d, 1);
      poll();
      exq = '{rows[i].d};
      rd(rows[i].ra, 1'b0);
    end
    exq = '{8'ha5};
    rd(16'h0fff, 1'b0);
    exq = '{8'h5a};
    rd(16'h0000, 1'b1);
    exq = '{8'ha5, 8'h5a};
    rd(16'h0fff, 1'b0);
    foreach (bad[i])
    begin
      bus_master_model_i.start();
      bus_master_model_i.send(bad[i], nak);
      chk(8'(nak), 8'h1);
      bus_master_model_i.stop();
    end
    wr(16'h0080, 8'h00, 66);
    poll();
    exq = '{8'h40, 8'h41, 8'h02};
    rd(16'h0080, 1'b0);
    aph(16'h0000);
    bus_master_model_i.send(8'hee, nak);
    mr_n = 1'b0;
    cyc(5);
    mr_n = 1'b1;
    cyc(20);
    chk(8'(reset_oe_n), 8'h1);
    mr_n = 1'b0;
    t0 = cyc_n;
    cyc(30);
    mr_n = 1'b1;
    chk(8'(reset_oe_n), 8'h0);
    bus_master_model_i.stop();
    wrel();
    chk(8'(cyc_n - t0 >= HOLD && cyc_n - t0 <= HOLD + 30), 8'h1);
    exq = '{8'h5a};
    rd(16'h0000, 1'b0);
    wr(16'h0010, 8'h77, 1);
    supply_ok = 1'b0;
    cyc(10);
    chk(8'(reset_oe_n), 8'h0);
    chk(8'(busy), 8'h1);
    cyc(PROG);
    supply_ok = 1'b1;
    wrel();
    exq = '{8'h77};
    rd(16'h0010, 1'b0);
    tally_and_finish();
  end
endmodule : serial_eeprom_slave_tb
